// ===== emi_pkg.sv
// constants and types shared by the external memory pin interface
package emi_pkg;
	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int NUM_STATIC = 8;
	localparam int NUM_SDRAM = 2;
	localparam int BANK_W = 3;
	localparam int ROW_W = 13;
	localparam int COL_W = 10;
	localparam int CNT_W = 8;
	localparam int WAIT_W = 4;
	// sdram address layout on the pins
	localparam int SD_BA_LO = 13;
	localparam int SD_BA_HI = 14;
	localparam int AP_BIT = 10;
	localparam int SD_HI_PAD = ADDR_W - SD_BA_HI - 1;
	localparam int COL_PAD = SD_BA_LO - AP_BIT - 1;
	// ----------------------------------------------------------------
	// data width codes, shared by the boot strap and per-request width
	// ----------------------------------------------------------------
	localparam logic [1:0] WIDTH_RSVD = 2'h0;
	localparam logic [1:0] WIDTH_BYTE = 2'h1;
	localparam logic [1:0] WIDTH_HALF = 2'h2;
	localparam logic [1:0] WIDTH_WORD = 2'h3;
	localparam logic [BANK_W-1:0] BOOT_BANK = 3'h0;
	localparam logic [LANES-1:0] MASK_BYTE = 4'h1;
	localparam logic [LANES-1:0] MASK_HALF = 4'h3;
	localparam logic [LANES-1:0] MASK_WORD = 4'hf;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 2;
	localparam logic [CNT_W-1:0] SYNC_LAT = 8'h02;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam int TRCD_DEF = 2;
	localparam int CAS_LAT_DEF = 2;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_STATIC,
		ST_RDHOLD,
		ST_SDACT,
		ST_SDCMD,
		ST_SDLAT,
		ST_HANDOFF
	} emi_state_t;
endpackage

// ===== emi_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module emi_sync #(
	parameter int W = 1
) (
	input wire logic mclk_in, // system clock
	input wire logic [W-1:0] d_in, // asynchronous pin level
	output logic [W-1:0] q_out // level in the clock domain
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	// first stage feeds only the second stage
	always_comb begin
		nxt_meta = d_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge mclk_in) begin
		meta_ff <= nxt_meta;
		sync_ff <= nxt_sync;
	end

	assign q_out = sync_ff;
endmodule
`default_nettype wire

// ===== emi_pins.sv
// external memory pin sequencer for static banks and sdram
`timescale 1ns/1ps
`default_nettype none
module emi_pins #(
	parameter int TRCD_CYC = emi_pkg::TRCD_DEF, // activate to command
	parameter int CAS_LAT = emi_pkg::CAS_LAT_DEF // sdram read latency
) (
	input wire logic mclk_in, // system clock
	input wire logic reset_n_in, // synchronous reset, low
	input wire logic req_valid_in, // access request
	input wire logic req_write_in, // 1 write, 0 read
	input wire logic req_sdram_in, // 1 sdram, 0 static bank
	input wire logic [emi_pkg::BANK_W-1:0] req_bank_in, // bank, bit 0 for sdram
	input wire logic [1:0] req_width_in, // width code, not static bank 0
	input wire logic [emi_pkg::WAIT_W-1:0] req_wait_in, // static access cycles
	input wire logic [emi_pkg::ADDR_W-1:0] req_addr_in, // static address
	input wire logic [emi_pkg::ROW_W-1:0] req_row_in, // sdram row
	input wire logic [emi_pkg::COL_W-1:0] req_col_in, // sdram column
	input wire logic [1:0] req_ibank_in, // sdram internal bank
	input wire logic req_auto_pre_in, // auto precharge
	input wire logic [emi_pkg::DATA_W-1:0] req_wdata_in, // write data
	input wire logic [emi_pkg::LANES-1:0] req_be_in, // byte lanes, high on
	input wire logic [emi_pkg::DATA_W-1:0] ext_data_bus_in, // data pins in
	input wire logic ext_wait_n_in, // wait pin, low
	input wire logic ext_master_request_in, // bus request pin
	input wire logic [1:0] boot_bank_width_in, // boot width strap
	output logic req_ready_out, // can take a request
	output logic rsp_valid_out, // read data pulse
	output logic [emi_pkg::DATA_W-1:0] rsp_rdata_out, // read data
	output logic [emi_pkg::ADDR_W-1:0] ext_addr_out, // address pins
	output logic [emi_pkg::DATA_W-1:0] ext_data_bus_out, // data pins out
	output logic ext_data_bus_oe_out, // data pins driven
	output logic ext_ctrl_oe_out, // address and strobes driven
	output logic [emi_pkg::NUM_STATIC-1:0] static_bank_select_n_out, // static cs
	output logic [emi_pkg::NUM_SDRAM-1:0] sdram_chip_select_n_out, // sdram cs
	output logic sdram_row_strobe_n_out, // shared row strobe
	output logic sdram_column_strobe_n_out, // shared column strobe
	output logic sdram_clock_enable_out, // sdram clock enable
	output logic shared_write_strobe_n_out, // sdram / 16-bit write
	output logic read_strobe_n_out, // output enable to memory
	output logic [emi_pkg::LANES-1:0] byte_write_enable_n_out, // lanes / masks
	output logic system_clock_out, // clock to sdram
	output logic ext_master_grant_out, // pins released
	output logic [1:0] boot_width_out // captured boot width
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam logic [emi_pkg::CNT_W-1:0] TRCD_M1 = emi_pkg::CNT_W'(TRCD_CYC - 1);
	localparam logic [emi_pkg::CNT_W-1:0] RD_LAT = emi_pkg::CNT_W'(CAS_LAT - 1) +
		emi_pkg::SYNC_LAT;
	emi_pkg::emi_state_t state_ff, nxt_state;
	logic [emi_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
	logic write_ff, nxt_write;
	logic ap_ff, nxt_ap;
	logic [1:0] ibank_ff, nxt_ibank;
	logic [1:0] width_ff, nxt_width;
	logic [emi_pkg::COL_W-1:0] col_ff, nxt_col;
	logic [emi_pkg::LANES-1:0] be_ff, nxt_be;
	logic [1:0] boot_ff, nxt_boot;
	logic ready_ff, nxt_ready;
	logic rsp_ff, nxt_rsp;
	logic [emi_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
	logic [emi_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
	logic [emi_pkg::DATA_W-1:0] dout_ff, nxt_dout;
	logic doe_ff, nxt_doe;
	logic coe_ff, nxt_coe;
	logic [emi_pkg::NUM_STATIC-1:0] scs_ff, nxt_scs;
	logic [emi_pkg::NUM_SDRAM-1:0] dcs_ff, nxt_dcs;
	logic ras_ff, nxt_ras;
	logic cas_ff, nxt_cas;
	logic cke_ff, nxt_cke;
	logic we_ff, nxt_we;
	logic oe_ff, nxt_oe;
	logic [emi_pkg::LANES-1:0] wbe_ff, nxt_wbe;
	logic grant_ff, nxt_grant;
	logic [emi_pkg::DATA_W-1:0] data_s;
	logic wait_n_s;
	logic mreq_s;
	logic [1:0] strap_s;
	logic [1:0] eff_width;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// data is sampled late by the sync depth; reads hold the strobe to cover it
	emi_sync #(.W(emi_pkg::DATA_W + 4)) u_sync (
		.mclk_in(mclk_in),
		.d_in({ext_data_bus_in, ext_wait_n_in, ext_master_request_in, boot_bank_width_in}),
		.q_out({data_s, wait_n_s, mreq_s, strap_s})
	);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// active-low one-hot select of n lines
	function automatic logic [emi_pkg::NUM_STATIC-1:0] sel_n(input logic [2:0] b);
		logic [emi_pkg::NUM_STATIC-1:0] s;
		s = '1;
		s[b] = 1'b0;
		return s;
	endfunction

	// byte lanes that a bank of this width carries
	function automatic logic [emi_pkg::LANES-1:0] lane_mask(input logic [1:0] w);
		logic [emi_pkg::LANES-1:0] m;
		m = emi_pkg::MASK_WORD;
		if (w == emi_pkg::WIDTH_BYTE) begin
			m = emi_pkg::MASK_BYTE;
		end else if (w == emi_pkg::WIDTH_HALF) begin
			m = emi_pkg::MASK_HALF;
		end
		return m;
	endfunction

	// bank 0 boots with the strap width; sdram never runs byte wide
	always_comb begin
		eff_width = req_width_in;
		if (!req_sdram_in && req_bank_in == emi_pkg::BOOT_BANK) begin
			eff_width = boot_ff;
		end
		if (req_sdram_in && req_width_in != emi_pkg::WIDTH_WORD) begin
			eff_width = emi_pkg::WIDTH_HALF;
		end
		if (eff_width == emi_pkg::WIDTH_RSVD) begin
			eff_width = emi_pkg::WIDTH_WORD; // reserved code treated as word
		end
	end

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_write = write_ff;
		nxt_ap = ap_ff;
		nxt_ibank = ibank_ff;
		nxt_width = width_ff;
		nxt_col = col_ff;
		nxt_be = be_ff;
		nxt_boot = boot_ff;
		nxt_rsp = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_addr = addr_ff;
		nxt_dout = dout_ff;
		nxt_doe = doe_ff;
		nxt_coe = coe_ff;
		nxt_scs = scs_ff;
		nxt_dcs = dcs_ff;
		nxt_ras = ras_ff;
		nxt_cas = cas_ff;
		nxt_cke = 1'b1;
		nxt_we = we_ff;
		nxt_oe = oe_ff;
		nxt_wbe = wbe_ff;
		nxt_grant = grant_ff;
		unique case (state_ff)
			emi_pkg::ST_IDLE: begin
				if (mreq_s) begin
					nxt_coe = 1'b0;
					nxt_grant = 1'b1;
					nxt_state = emi_pkg::ST_HANDOFF;
				end else if (req_valid_in && ready_ff) begin
					nxt_write = req_write_in;
					nxt_width = eff_width;
					nxt_be = req_be_in;
					nxt_ap = req_auto_pre_in;
					nxt_ibank = req_ibank_in;
					nxt_col = req_col_in;
					nxt_dout = req_wdata_in;
					if (req_sdram_in) begin
						// activate: row on the low bits, internal bank above
						nxt_addr = {{emi_pkg::SD_HI_PAD{1'b0}}, req_ibank_in, req_row_in};
						nxt_dcs[req_bank_in[0]] = 1'b0;
						nxt_ras = 1'b0;
						nxt_cnt = TRCD_M1;
						nxt_state = emi_pkg::ST_SDACT;
					end else begin
						nxt_addr = req_addr_in;
						nxt_scs = sel_n(req_bank_in);
						nxt_cnt = emi_pkg::CNT_W'(req_wait_in);
						if (req_write_in) begin
							nxt_doe = 1'b1;
							nxt_wbe = ~(req_be_in & lane_mask(eff_width));
							nxt_we = (eff_width != emi_pkg::WIDTH_HALF);
						end else begin
							nxt_oe = 1'b0;
						end
						nxt_state = emi_pkg::ST_STATIC;
					end
				end
			end
			emi_pkg::ST_STATIC: begin
				if (cnt_ff != emi_pkg::CNT_ZERO) begin
					nxt_cnt = cnt_ff - emi_pkg::CNT_ONE;
				end else if (!wait_n_s) begin
					nxt_state = emi_pkg::ST_STATIC;
				end else if (write_ff) begin
					nxt_scs = '1;
					nxt_doe = 1'b0;
					nxt_wbe = '1;
					nxt_we = 1'b1;
					nxt_state = emi_pkg::ST_IDLE;
				end else begin
					nxt_cnt = emi_pkg::SYNC_LAT - emi_pkg::CNT_ONE;
					nxt_state = emi_pkg::ST_RDHOLD;
				end
			end
			emi_pkg::ST_RDHOLD: begin
				// strobe stays low until the synchronised data has caught up
				if (cnt_ff != emi_pkg::CNT_ZERO) begin
					nxt_cnt = cnt_ff - emi_pkg::CNT_ONE;
				end else begin
					nxt_rdata = data_s;
					nxt_rsp = 1'b1;
					nxt_scs = '1;
					nxt_oe = 1'b1;
					nxt_state = emi_pkg::ST_IDLE;
				end
			end
			emi_pkg::ST_SDACT: begin
				// select stays low over the gap; high strobes make those cycles a nop
				nxt_ras = 1'b1;
				if (cnt_ff != emi_pkg::CNT_ZERO) begin
					nxt_cnt = cnt_ff - emi_pkg::CNT_ONE;
				end else begin
					nxt_cas = 1'b0;
					nxt_we = !write_ff;
					nxt_addr = {{emi_pkg::SD_HI_PAD{1'b0}}, ibank_ff, {emi_pkg::COL_PAD{1'b0}},
						ap_ff, col_ff};
					nxt_wbe = ~be_ff;
					nxt_doe = write_ff;
					nxt_state = emi_pkg::ST_SDCMD;
				end
			end
			emi_pkg::ST_SDCMD: begin
				nxt_cas = 1'b1;
				nxt_we = 1'b1;
				nxt_dcs = '1;
				nxt_doe = 1'b0;
				if (write_ff) begin
					nxt_wbe = '1;
					nxt_state = emi_pkg::ST_IDLE;
				end else begin
					nxt_cnt = RD_LAT;
					nxt_state = emi_pkg::ST_SDLAT;
				end
			end
			emi_pkg::ST_SDLAT: begin
				// masks stay put through the read latency
				if (cnt_ff != emi_pkg::CNT_ZERO) begin
					nxt_cnt = cnt_ff - emi_pkg::CNT_ONE;
				end else begin
					nxt_rdata = data_s;
					nxt_rsp = 1'b1;
					nxt_wbe = '1;
					nxt_state = emi_pkg::ST_IDLE;
				end
			end
			emi_pkg::ST_HANDOFF: begin
				// the external master keeps the sdram refreshed meanwhile
				if (!mreq_s) begin
					nxt_coe = 1'b1;
					nxt_grant = 1'b0;
					nxt_state = emi_pkg::ST_IDLE;
				end
			end
		endcase
		nxt_ready = (nxt_state == emi_pkg::ST_IDLE) && !mreq_s;
		if (!reset_n_in) begin
			// strap is caught while reset is held, after the sync has settled
			nxt_boot = strap_s;
			nxt_state = emi_pkg::ST_IDLE;
			nxt_cnt = emi_pkg::CNT_ZERO;
			nxt_ready = 1'b0;
			nxt_rsp = 1'b0;
			nxt_doe = 1'b0;
			nxt_coe = 1'b1;
			nxt_scs = '1;
			nxt_dcs = '1;
			nxt_ras = 1'b1;
			nxt_cas = 1'b1;
			nxt_cke = 1'b0;
			nxt_we = 1'b1;
			nxt_oe = 1'b1;
			nxt_wbe = '1;
			nxt_grant = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		state_ff <= nxt_state;
		cnt_ff <= nxt_cnt;
		write_ff <= nxt_write;
		ap_ff <= nxt_ap;
		ibank_ff <= nxt_ibank;
		width_ff <= nxt_width;
		col_ff <= nxt_col;
		be_ff <= nxt_be;
		boot_ff <= nxt_boot;
		ready_ff <= nxt_ready;
		rsp_ff <= nxt_rsp;
		rdata_ff <= nxt_rdata;
		addr_ff <= nxt_addr;
		dout_ff <= nxt_dout;
		doe_ff <= nxt_doe;
		coe_ff <= nxt_coe;
		scs_ff <= nxt_scs;
		dcs_ff <= nxt_dcs;
		ras_ff <= nxt_ras;
		cas_ff <= nxt_cas;
		cke_ff <= nxt_cke;
		we_ff <= nxt_we;
		oe_ff <= nxt_oe;
		wbe_ff <= nxt_wbe;
		grant_ff <= nxt_grant;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// every pin comes from a flop except the clock, which cannot
	assign system_clock_out = mclk_in;
	assign req_ready_out = ready_ff;
	assign rsp_valid_out = rsp_ff;
	assign rsp_rdata_out = rdata_ff;
	assign ext_addr_out = addr_ff;
	assign ext_data_bus_out = dout_ff;
	assign ext_data_bus_oe_out = doe_ff;
	assign ext_ctrl_oe_out = coe_ff;
	assign static_bank_select_n_out = scs_ff;
	assign sdram_chip_select_n_out = dcs_ff;
	assign sdram_row_strobe_n_out = ras_ff;
	assign sdram_column_strobe_n_out = cas_ff;
	assign sdram_clock_enable_out = cke_ff;
	assign shared_write_strobe_n_out = we_ff;
	assign read_strobe_n_out = oe_ff;
	assign byte_write_enable_n_out = wbe_ff;
	assign ext_master_grant_out = grant_ff;
	assign boot_width_out = boot_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_sd_cs;
		@(posedge mclk_in) disable iff (!reset_n_in) !(dcs_ff == '0);
	endproperty
	a_sd_cs: assert property (p_sd_cs) else $error("both sdram selects low");
	property p_st_cs;
		@(posedge mclk_in) disable iff (!reset_n_in) $onehot0(~scs_ff);
	endproperty
	a_st_cs: assert property (p_st_cs) else $error("more than one static select");
	property p_ap;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(!cas_ff && ras_ff) |-> ext_addr_out[emi_pkg::AP_BIT] == ap_ff;
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge bit wrong");
	property p_ba;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(!ras_ff || !cas_ff) |-> ext_addr_out[emi_pkg::SD_BA_HI:emi_pkg::SD_BA_LO] == ibank_ff;
	endproperty
	a_ba: assert property (p_ba) else $error("sdram bank bits wrong");
	property p_we8;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(scs_ff != '1 && width_ff == emi_pkg::WIDTH_BYTE) |-> we_ff;
	endproperty
	a_we8: assert property (p_we8) else $error("write strobe on byte bank");
	property p_wait;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(state_ff == emi_pkg::ST_STATIC && cnt_ff == emi_pkg::CNT_ZERO && !wait_n_s)
			|=> state_ff == emi_pkg::ST_STATIC && scs_ff == $past(scs_ff);
	endproperty
	a_wait: assert property (p_wait) else $error("access ended under wait");
	property p_idle;
		@(posedge mclk_in) disable iff (!reset_n_in)
			state_ff == emi_pkg::ST_IDLE |-> scs_ff == '1 && dcs_ff == '1 && oe_ff && we_ff
			&& wbe_ff == '1;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe active while idle");
	property p_hand;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(state_ff == emi_pkg::ST_IDLE && mreq_s) |=> !coe_ff && grant_ff && !ready_ff;
	endproperty
	a_hand: assert property (p_hand) else $error("bus not released");
	property p_rd;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(state_ff == emi_pkg::ST_STATIC && !write_ff) |-> !oe_ff ##1 (!oe_ff || rsp_ff);
	endproperty
	a_rd: assert property (p_rd) else $error("read strobe dropped early");
	property p_trcd;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(!ras_ff && cas_ff) |-> ##TRCD_CYC (!cas_ff && ras_ff);
	endproperty
	a_trcd: assert property (p_trcd) else $error("command not after activate");
	property p_mask;
		@(posedge mclk_in) disable iff (!reset_n_in)
			state_ff == emi_pkg::ST_SDCMD |-> wbe_ff == ~be_ff && !cke_ff == 1'b0;
	endproperty
	a_mask: assert property (p_mask) else $error("sdram mask or cke wrong");
	property p_sdw;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(state_ff == emi_pkg::ST_SDACT || state_ff == emi_pkg::ST_SDCMD)
			|-> width_ff != emi_pkg::WIDTH_BYTE;
	endproperty
	a_sdw: assert property (p_sdw) else $error("byte wide sdram access");
endmodule
`default_nettype wire

// ===== emi_mem_model.sv
// memory and io device model facing the external memory pins
`timescale 1ns/1ps
`default_nettype none
module emi_mem_model (
	input wire logic mclk_in, // system clock
	input wire logic [7:0] static_bank_select_n_in, // static selects
	input wire logic [1:0] sdram_chip_select_n_in, // sdram selects
	input wire logic sdram_column_strobe_n_in, // column strobe
	input wire logic shared_write_strobe_n_in, // write strobe
	input wire logic read_strobe_n_in, // output enable
	input wire logic [3:0] byte_write_enable_n_in, // lanes or masks
	input wire logic [23:0] ext_addr_in, // address pins
	input wire logic [3:0] wait_cycles_in, // wait length asked by the bench
	output logic [31:0] ext_data_bus_out, // read data onto the pins
	output logic ext_wait_n_out // wait pin, low
);
	logic sd_live = 1'b0;
	logic [31:0] sd_val = 32'h0;
	logic [3:0] wait_cnt = 4'h0;
	logic [7:0] cs_prev = 8'hff;
	logic [31:0] bus_q = 32'h0;
	initial ext_wait_n_out = 1'b1;
	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// a released bus toggles every cycle so a stale word never passes
	always @(posedge mclk_in) begin
		if (sdram_chip_select_n_in != 2'h3 && !sdram_column_strobe_n_in
			&& shared_write_strobe_n_in) begin
			sd_val <= {8'h5a, ext_addr_in};
			sd_live <= 1'b1;
		end else if (byte_write_enable_n_in == 4'hf) begin
			sd_live <= 1'b0; // masks up ends the burst
		end
		if (sd_live) begin
			bus_q <= sd_val;
		end else begin
			bus_q <= ~bus_q;
		end
	end
	// static parts are asynchronous: the word follows the address while read
	assign ext_data_bus_out = (static_bank_select_n_in != 8'hff && !read_strobe_n_in) ?
		{8'h5a, ext_addr_in} : bus_q;
	// ----------------------------------------------------------------
	// wait pin
	// ----------------------------------------------------------------
	// slow device: holds wait low for a set count from select
	always @(posedge mclk_in) begin
		cs_prev <= static_bank_select_n_in;
		if (cs_prev == 8'hff && static_bank_select_n_in != 8'hff) begin
			wait_cnt <= wait_cycles_in;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end
		ext_wait_n_out <= (wait_cnt == 4'h0);
	end
endmodule
`default_nettype wire

// ===== emi_pins_tb.sv
// self-checking bench for the external memory pin sequencer
`timescale 1ns/1ps
`default_nettype none
module emi_pins_tb;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic req_valid_in = 1'b0, req_write_in = 1'b0, req_sdram_in = 1'b0;
	logic req_auto_pre_in = 1'b0, ext_master_request_in = 1'b0;
	logic [2:0] req_bank_in = 3'h0;
	logic [1:0] req_width_in = 2'h3, req_ibank_in = 2'h0, boot_bank_width_in = 2'h3;
	logic [3:0] req_wait_in = 4'h1, req_be_in = 4'hf, wait_cycles = 4'h0;
	logic [23:0] req_addr_in = 24'h0;
	logic [12:0] req_row_in = 13'h0;
	logic [9:0] req_col_in = 10'h0;
	logic [31:0] req_wdata_in = 32'h0, seed = 32'h2174;
	logic req_ready_out, rsp_valid_out, ext_data_bus_oe_out, ext_ctrl_oe_out;
	logic sdram_row_strobe_n_out, sdram_column_strobe_n_out, sdram_clock_enable_out;
	logic shared_write_strobe_n_out, read_strobe_n_out, system_clock_out;
	logic ext_master_grant_out, ext_wait_n_in;
	logic [31:0] rsp_rdata_out, ext_data_bus_out, model_data;
	logic [23:0] ext_addr_out;
	logic [7:0] static_bank_select_n_out;
	logic [1:0] sdram_chip_select_n_out, boot_width_out;
	logic [3:0] byte_write_enable_n_out;
	wire logic [31:0] ext_data_bus_in;
	logic [31:0] exp_q[$];
	int num_errors = 0;
	int n_checks = 0;
	// bus level: whoever enables wins, the model otherwise
	assign ext_data_bus_in = ext_data_bus_oe_out ? ext_data_bus_out : model_data;
	always #4 mclk_in = ~mclk_in;
	emi_pins dut_u (.mclk_in, .reset_n_in, .req_valid_in, .req_write_in, .req_sdram_in,
		.req_bank_in, .req_width_in, .req_wait_in, .req_addr_in, .req_row_in, .req_col_in,
		.req_ibank_in, .req_auto_pre_in, .req_wdata_in, .req_be_in, .ext_data_bus_in,
		.ext_wait_n_in, .ext_master_request_in, .boot_bank_width_in, .req_ready_out,
		.rsp_valid_out, .rsp_rdata_out, .ext_addr_out, .ext_data_bus_out,
		.ext_data_bus_oe_out, .ext_ctrl_oe_out, .static_bank_select_n_out,
		.sdram_chip_select_n_out, .sdram_row_strobe_n_out, .sdram_column_strobe_n_out,
		.sdram_clock_enable_out, .shared_write_strobe_n_out, .read_strobe_n_out,
		.byte_write_enable_n_out, .system_clock_out, .ext_master_grant_out,
		.boot_width_out);
	emi_mem_model model_u (.mclk_in, .static_bank_select_n_in(static_bank_select_n_out),
		.sdram_chip_select_n_in(sdram_chip_select_n_out),
		.sdram_column_strobe_n_in(sdram_column_strobe_n_out),
		.shared_write_strobe_n_in(shared_write_strobe_n_out),
		.read_strobe_n_in(read_strobe_n_out), .byte_write_enable_n_in(byte_write_enable_n_out),
		.ext_addr_in(ext_addr_out), .wait_cycles_in(wait_cycles),
		.ext_data_bus_out(model_data), .ext_wait_n_out(ext_wait_n_in));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic cond(input int w);
		case (w)
			0: return (&static_bank_select_n_out) === 1'b0;
			1: return (&sdram_chip_select_n_out) === 1'b0 && sdram_row_strobe_n_out === 1'b0;
			2: return (&sdram_chip_select_n_out) === 1'b0 && sdram_column_strobe_n_out === 1'b0;
			3: return req_ready_out === 1'b1;
			default: return ext_master_grant_out === 1'b1;
		endcase
	endfunction
	// bounded wait at falling edges; a spent bound ends the run
	task automatic wait_for(input int w);
		for (int i = 0; i < 60 && !cond(w); i++) @(negedge mclk_in);
		if (!cond(w)) begin
			chk("wait bound", 32'h1, 32'h0);
			give_verdict();
		end
	endtask
	// hold valid until the edge that takes it, then drop it
	task automatic send();
		req_valid_in = 1'b1;
		wait_for(3);
		@(posedge mclk_in);
		@(negedge mclk_in);
		req_valid_in = 1'b0;
	endtask
	task automatic rst(input logic [1:0] s);
		reset_n_in = 1'b0;
		boot_bank_width_in = s;
		repeat (8) @(negedge mclk_in);
		chk("selects in reset", 32'hff, 32'(static_bank_select_n_out));
		chk("cke in reset", 32'h0, 32'(sdram_clock_enable_out));
		reset_n_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		chk("cke", 32'h1, 32'(sdram_clock_enable_out));
		chk("boot width", 32'(s), 32'(boot_width_out));
		chk("clock out", 32'(mclk_in), 32'(system_clock_out));
	endtask
	// ----------------------------------------------------------------
	// static and sdram accesses
	// ----------------------------------------------------------------
	task automatic st_op(input logic wr, input logic [2:0] b, input logic [1:0] wd,
		input logic [3:0] wt);
		logic [1:0] ew;
		logic [3:0] m;
		ew = (b == emi_pkg::BOOT_BANK) ? boot_bank_width_in : wd;
		m = (ew == emi_pkg::WIDTH_BYTE) ? emi_pkg::MASK_BYTE :
			(ew == emi_pkg::WIDTH_HALF) ? emi_pkg::MASK_HALF : emi_pkg::MASK_WORD;
		req_write_in = wr;
		req_sdram_in = 1'b0;
		req_bank_in = b;
		req_width_in = wd;
		req_wait_in = wt;
		req_addr_in = 24'(rnd());
		req_wdata_in = rnd();
		req_be_in = 4'(rnd());
		send();
		wait_for(0);
		chk("static select", 32'(8'(~(8'h1 << b))), 32'(static_bank_select_n_out));
		chk("address", 32'(req_addr_in), 32'(ext_addr_out));
		chk("data drive", 32'(wr), 32'(ext_data_bus_oe_out));
		if (wr) begin
			chk("byte enables", 32'(4'(~(req_be_in & m))), 32'(byte_write_enable_n_out));
			chk("write strobe", 32'(ew != emi_pkg::WIDTH_HALF), 32'(shared_write_strobe_n_out));
			chk("write data", req_wdata_in, ext_data_bus_out);
		end else begin
			chk("read strobe", 32'h0, 32'(read_strobe_n_out));
			exp_q.push_back({8'h5a, req_addr_in});
		end
		wait_for(3);
		chk("idle selects", 32'hff, 32'(static_bank_select_n_out));
	endtask
	task automatic sd_op(input logic wr, input logic c, input logic [1:0] wd);
		req_write_in = wr;
		req_sdram_in = 1'b1;
		req_bank_in = {2'h0, c};
		req_width_in = wd;
		req_ibank_in = 2'(rnd());
		req_row_in = 13'(rnd());
		req_col_in = 10'(rnd());
		req_auto_pre_in = 1'(rnd());
		req_be_in = 4'(rnd());
		req_wdata_in = rnd();
		send();
		wait_for(1);
		chk("sdram select", 32'(2'(~(2'h1 << c))), 32'(sdram_chip_select_n_out));
		chk("internal bank", 32'(req_ibank_in), 32'(ext_addr_out[14:13]));
		wait_for(2);
		chk("sdram select", 32'(2'(~(2'h1 << c))), 32'(sdram_chip_select_n_out));
		chk("row strobe", 32'h1, 32'(sdram_row_strobe_n_out));
		chk("auto precharge", 32'(req_auto_pre_in), 32'(ext_addr_out[10]));
		chk("sdram write", 32'(!wr), 32'(shared_write_strobe_n_out));
		chk("masks", 32'(4'(~req_be_in)), 32'(byte_write_enable_n_out));
		chk("data drive", 32'(wr), 32'(ext_data_bus_oe_out));
		if (wr) chk("sdram data", req_wdata_in, ext_data_bus_out);
		if (!wr) exp_q.push_back({8'h5a, 9'h0, req_ibank_in, 2'h0, req_auto_pre_in, req_col_in});
		wait_for(3);
	endtask
	// response watcher: oldest note against each read pulse
	always @(negedge mclk_in) begin
		if (rsp_valid_out === 1'b1) begin
			if (exp_q.size() == 0) chk("spare response", 32'h0, 32'h1);
			else chk("read data", exp_q.pop_front(), rsp_rdata_out);
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int s = 0; s < 4; s++) begin
			rst(2'(s));
			st_op(1'b1, 3'h0, emi_pkg::WIDTH_BYTE, 4'h1);
		end
		for (int b = 0; b < 8; b++) begin
			st_op(1'b1, 3'(b), 2'(rnd()), 4'h1);
			wait_cycles = 4'h6;
			st_op(1'b0, 3'(b), emi_pkg::WIDTH_WORD, 4'(b));
			wait_cycles = 4'h0;
		end
		for (int k = 0; k < 12; k++) begin
			sd_op(k[0], k[1], k[0] ? 2'(k[3:2] + 1) : emi_pkg::WIDTH_WORD);
		end
		ext_master_request_in = 1'b1;
		wait_for(4);
		chk("pins released", 32'h0, 32'(ext_ctrl_oe_out));
		chk("ready in handoff", 32'h0, 32'(req_ready_out));
		ext_master_request_in = 1'b0;
		wait_for(3);
		chk("pins taken back", 32'h1, 32'(ext_ctrl_oe_out));
		st_op(1'b0, 3'h0, emi_pkg::WIDTH_WORD, 4'h0);
		for (int i = 0; i < 50 && exp_q.size() != 0; i++) @(negedge mclk_in);
		chk("pending reads", 32'h0, 32'(exp_q.size()));
		give_verdict();
	end
endmodule
`default_nettype wire
